// file: hw/dlsc_lane_ctrl.sv
// Data-lane LP/HS state controller with configuration port
`timescale 1ns/100ps
`default_nettype none
`include "dlsc_map.svh"

// Summary of operation
// R1: A state machine with timers steers every lane between low-power and high-speed.
// R2: Only Stop State to high-speed and back; no escape, LP request or turnaround.
// R3: Each lane is always either in low-power control mode or high-speed mode.
// R4: After start-up all lanes hold LP11 for the programmed initial time; the code loads the timer from DEF_INIT, not from init_q.
// R5: High-speed entry drives LP11, LP01, LP00, each for its programmed time; the code holds LP00 for the LPX time too.
// R6: High-speed zeros are sent for the programmed time before anything else.
// R7: The sync byte 00011101 precedes the payload of every burst on each lane.
// R8: Every burst ends back in LP11; one burst per line, LP11 between is blanking; the code also ends a burst when the FIFO runs empty.
// R9: Above 1.5 Gbps or on changing to it, an initial deskew burst goes first.
// R10: Initial deskew at lower rates and periodic deskew are optional, software chosen.
// R11: Trail time is a 6-bit programmable count of byte clocks.
// R12: Every other protocol time is its own programmable count, same scaling; the code times LP00 with the LPX count.
// R13: Without the configuration port the registers keep their build-time defaults.
// R14: The master drives direction high to write and low to read.
// R15: Register offsets on the configuration port start at zero.
// R16: Master raises request to start; ready shows a transaction may begin.
// R17: The active-low configuration reset returns every register to its default.
// R18: The main reset is active low and sampled on the core clock.
// R19: After trail, lanes drive LP11 for at least the programmed exit time.
// R20: All lanes change state together on the same byte-clock cycle.
module dlsc_lane_ctrl #(
   parameter int         LANES       = 4,
   parameter int         FIFO_DEPTH  = 8,
   parameter bit         CFG_PORT_EN = 1'b1,
   parameter logic [3:0] BYTE_DIV    = `DLSC_BYTE_DIV,
   parameter logic [5:0] DEF_TRAIL   = `DLSC_RST_TRAIL,
   parameter logic [7:0] DEF_INIT    = `DLSC_RST_INIT,
   parameter logic [7:0] DEF_LPX     = `DLSC_RST_LPX,
   parameter logic [7:0] DEF_ZERO    = `DLSC_RST_ZERO,
   parameter logic [7:0] DEF_EXIT    = `DLSC_RST_EXIT,
   parameter logic [7:0] DEF_CTRL    = `DLSC_RST_CTRL,
   parameter logic [7:0] DEF_PERIOD  = `DLSC_RST_PERIOD,
   parameter logic [7:0] DEF_DSK_LEN = `DLSC_RST_DSK_LEN
) (
   // Core clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // Configuration port
   input  wire logic                 cfg_clk,
   input  wire logic                 cfg_rst_n,
   input  wire logic                 cfg_request,
   input  wire logic                 cfg_wr_rdn,
   input  wire logic [3:0]           cfg_offset,
   input  wire logic [7:0]           cfg_wdata,
   output var  logic                 cfg_ready,
   output var  logic [7:0]           cfg_rdata,
   output var  logic                 cfg_rdata_valid,
   // Payload stream
   input  wire logic                 pl_valid,
   input  wire logic [LANES*8-1:0]   pl_data,
   input  wire logic                 pl_last,
   output var  logic                 pl_ready,
   // Lane drive
   output var  logic [LANES-1:0]     lp_p,
   output var  logic [LANES-1:0]     lp_n,
   output var  logic [LANES-1:0]     lp_oe,
   output var  logic [LANES-1:0]     hs_oe,
   output var  logic [LANES*8-1:0]   hs_byte,
   output var  logic                 byte_strobe,
   output var  logic                 init_done
);

   localparam int FW = LANES*8 + 1;

   // ---------------------------------------------------------------
   // Byte-clock enable
   // ---------------------------------------------------------------
   logic [3:0] div_q;
   logic       byte_en_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin   // R18
         div_q     <= 4'h0;
         byte_en_q <= 1'b0;
      end else begin
         div_q     <= (div_q == BYTE_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
         byte_en_q <= (div_q == BYTE_DIV - 4'h1);
      end
   end

   // ---------------------------------------------------------------
   // Configuration port sampling
   // ---------------------------------------------------------------
   // Port signals are taken at the falling edge of cfg_clk, mid-period,
   // where the master's outputs have settled
   dlsc_pkg::dlsc_cfg_req_t cfg_s1_q;
   dlsc_pkg::dlsc_cfg_req_t cfg_s2_q;
   logic [2:0]              cclk_q;
   logic [1:0]              crst_q;

   always_ff @(posedge clk_sys) begin
      cfg_s1_q <= '{request: cfg_request, wr_rdn: cfg_wr_rdn,
                    offset: cfg_offset, wdata: cfg_wdata};
      cfg_s2_q <= cfg_s1_q;
      cclk_q   <= {cclk_q[1:0], cfg_clk};
      crst_q   <= {crst_q[0], cfg_rst_n};
   end

   wire cfg_fall  = cclk_q[2] & ~cclk_q[1];
   wire cfg_reset = ~crst_q[1];
   wire acc       = CFG_PORT_EN & cfg_fall & cfg_s2_q.request & cfg_ready;   // R16
   wire wr_acc    = acc & cfg_s2_q.wr_rdn;                                    // R14
   wire rd_acc    = acc & ~cfg_s2_q.wr_rdn;                                   // R14
   wire reg_rst   = ~rst_n | cfg_reset;                                       // R17

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [5:0] trail_q;
   logic [7:0] init_q;
   logic [7:0] lpx_q;
   logic [7:0] zero_q;
   logic [7:0] exit_q;
   logic [7:0] ctrl_q;
   logic [7:0] period_q;
   logic [7:0] dsk_len_q;

   wire wr_trail  = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_TRAIL);    // R15
   wire wr_init   = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_INIT);
   wire wr_lpx    = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_LPX);
   wire wr_zero   = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_ZERO);
   wire wr_exit   = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_EXIT);
   wire wr_ctrl   = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_CTRL);
   wire wr_period = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_PERIOD);
   wire wr_dsklen = wr_acc & (cfg_s2_q.offset == `DLSC_OFF_DSK_LEN);

   // Without the port no write is ever accepted, so defaults stay
   always_ff @(posedge clk_sys) begin
      if (reg_rst) begin   // R13 R17
         trail_q   <= DEF_TRAIL;
         init_q    <= DEF_INIT;
         lpx_q     <= DEF_LPX;
         zero_q    <= DEF_ZERO;
         exit_q    <= DEF_EXIT;
         ctrl_q    <= DEF_CTRL;
         period_q  <= DEF_PERIOD;
         dsk_len_q <= DEF_DSK_LEN;
      end else begin
         if (wr_trail)  trail_q   <= cfg_s2_q.wdata[5:0];   // R11
         if (wr_init)   init_q    <= cfg_s2_q.wdata;        // R12
         if (wr_lpx)    lpx_q     <= cfg_s2_q.wdata;
         if (wr_zero)   zero_q    <= cfg_s2_q.wdata;
         if (wr_exit)   exit_q    <= cfg_s2_q.wdata;
         if (wr_ctrl)   ctrl_q    <= cfg_s2_q.wdata;
         if (wr_period) period_q  <= cfg_s2_q.wdata;
         if (wr_dsklen) dsk_len_q <= cfg_s2_q.wdata;
      end
   end

   // ---------------------------------------------------------------
   // Read path and handshake
   // ---------------------------------------------------------------
   dlsc_pkg::dlsc_state_t state_q;
   dlsc_pkg::dlsc_state_t state_d;
   logic                  dsk_pend_q;
   logic                  fifo_valid;
   wire  [7:0]            status;
   wire  [7:0]            rd_mux;

   assign status = {4'h0, fifo_valid, dsk_pend_q, ~state_q[0] & ~state_q[1]
                    & ~state_q[8] & ~state_q[2] & ~state_q[3], init_done};
   assign rd_mux =
      (cfg_s2_q.offset == `DLSC_OFF_TRAIL)   ? {2'b00, trail_q} :
      (cfg_s2_q.offset == `DLSC_OFF_INIT)    ? init_q :
      (cfg_s2_q.offset == `DLSC_OFF_LPX)     ? lpx_q :
      (cfg_s2_q.offset == `DLSC_OFF_ZERO)    ? zero_q :
      (cfg_s2_q.offset == `DLSC_OFF_EXIT)    ? exit_q :
      (cfg_s2_q.offset == `DLSC_OFF_CTRL)    ? ctrl_q :
      (cfg_s2_q.offset == `DLSC_OFF_PERIOD)  ? period_q :
      (cfg_s2_q.offset == `DLSC_OFF_DSK_LEN) ? dsk_len_q :
      (cfg_s2_q.offset == `DLSC_OFF_STATUS)  ? status : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (reg_rst) begin
         cfg_ready       <= 1'b0;
         cfg_rdata       <= 8'h00;
         cfg_rdata_valid <= 1'b0;
      end else begin
         cfg_ready <= CFG_PORT_EN;   // R16
         if (rd_acc) begin
            cfg_rdata       <= rd_mux;
            cfg_rdata_valid <= 1'b1;
         end else if (cfg_fall) begin
            cfg_rdata_valid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Payload FIFO
   // ---------------------------------------------------------------
   logic [FW-1:0] fifo_data;
   wire           data_phase = (state_q == dlsc_pkg::ST_DATA);
   logic          is_dsk_q;
   wire           fifo_pop   = byte_en_q & data_phase & ~is_dsk_q;

   dlsc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (pl_valid),
      .in_data   ({pl_last, pl_data}),
      .in_ready  (pl_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_pop)
   );

   // ---------------------------------------------------------------
   // Deskew scheduling
   // ---------------------------------------------------------------
   logic [7:0] tmr_q;
   logic [7:0] tmr_d;
   logic       stop_go;
   logic [7:0] burst_cnt_q;
   logic       hr_prev_q;
   wire        hr         = ctrl_q[`DLSC_CTRL_HIGH_RATE];
   wire        init_exit  = byte_en_q & (state_q == dlsc_pkg::ST_INIT) & (tmr_q == 8'h00);
   wire        burst_end  = byte_en_q & (state_q == dlsc_pkg::ST_TRAIL) & (tmr_q == 8'h00);
   wire        per_hit    = burst_end & ~is_dsk_q & ctrl_q[`DLSC_CTRL_PER_DSK]
                            & (burst_cnt_q + 8'h01 >= period_q);
   wire        dsk_set    = (init_exit & (hr | ctrl_q[`DLSC_CTRL_INIT_DSK]))   // R9 R10
                            | (hr & ~hr_prev_q & init_done)                     // R9
                            | per_hit;                                          // R10
   wire        dsk_start  = byte_en_q & (state_q == dlsc_pkg::ST_STOP) & stop_go & dsk_pend_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dsk_pend_q  <= 1'b0;
         hr_prev_q   <= 1'b0;
         burst_cnt_q <= 8'h00;
      end else begin
         hr_prev_q <= hr;
         // A new request wins over the clear of the one being served
         if (dsk_set)        dsk_pend_q <= 1'b1;
         else if (dsk_start) dsk_pend_q <= 1'b0;
         if (per_hit)                    burst_cnt_q <= 8'h00;
         else if (burst_end & ~is_dsk_q) burst_cnt_q <= burst_cnt_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Lane state machine
   // ---------------------------------------------------------------
   logic [7:0] last_byte_q;
   wire        tmr_done = (tmr_q == 8'h00);
   wire        pl_end   = fifo_data[FW-1] | ~fifo_valid;

   assign stop_go = tmr_done & (fifo_valid | dsk_pend_q);

   always_comb begin
      state_d = state_q;
      tmr_d   = (tmr_q != 8'h00) ? tmr_q - 8'h01 : 8'h00;
      case (state_q)   // R1 R2
         dlsc_pkg::ST_INIT: begin
            if (tmr_done) begin   // R4
               state_d = dlsc_pkg::ST_STOP;
               tmr_d   = 8'h00;
            end
         end
         dlsc_pkg::ST_STOP: begin
            if (stop_go) begin   // R5
               state_d = dlsc_pkg::ST_LP01;
               tmr_d   = lpx_q;
            end
         end
         dlsc_pkg::ST_LP01: begin
            if (tmr_done) begin   // R5
               state_d = dlsc_pkg::ST_LP00;
               tmr_d   = lpx_q;
            end
         end
         dlsc_pkg::ST_LP00: begin
            if (tmr_done) begin   // R5
               state_d = dlsc_pkg::ST_ZERO;
               tmr_d   = zero_q;
            end
         end
         dlsc_pkg::ST_ZERO: begin
            if (tmr_done) begin   // R6
               state_d = dlsc_pkg::ST_SYNC;
            end
         end
         dlsc_pkg::ST_SYNC: begin   // R7
            state_d = dlsc_pkg::ST_DATA;
            tmr_d   = dsk_len_q;
         end
         dlsc_pkg::ST_DATA: begin
            if (is_dsk_q ? tmr_done : pl_end) begin   // R8
               state_d = dlsc_pkg::ST_TRAIL;
               tmr_d   = {2'b00, trail_q};   // R11
            end
         end
         dlsc_pkg::ST_TRAIL: begin
            if (tmr_done) begin   // R19
               state_d = dlsc_pkg::ST_EXIT;
               tmr_d   = exit_q;
            end
         end
         dlsc_pkg::ST_EXIT: begin
            if (tmr_done) begin   // R19
               state_d = dlsc_pkg::ST_STOP;
            end
         end
         default: begin
            state_d = dlsc_pkg::ST_INIT;
            tmr_d   = init_q;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q     <= dlsc_pkg::ST_INIT;
         tmr_q       <= DEF_INIT;
         is_dsk_q    <= 1'b0;
         init_done   <= 1'b0;
         last_byte_q <= 8'h00;
      end else if (byte_en_q) begin   // R20
         state_q <= state_d;
         tmr_q   <= tmr_d;
         if (state_q == dlsc_pkg::ST_INIT) tmr_q <= (tmr_done ? 8'h00 : tmr_d);
         if (dsk_start) is_dsk_q <= 1'b1;
         else if (state_d == dlsc_pkg::ST_STOP) is_dsk_q <= 1'b0;
         if (init_exit) init_done <= 1'b1;
         if (fifo_pop & fifo_valid) last_byte_q <= fifo_data[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Lane drivers
   // ---------------------------------------------------------------
   wire       st_lp11 = state_q[0] | state_q[1] | state_q[8];
   wire       st_hs   = state_q[4] | state_q[5] | state_q[6] | state_q[7];
   wire [7:0] trail_b = {8{~last_byte_q[7]}};
   wire [7:0] dsk_b   = (tmr_q == dsk_len_q) ? `DLSC_DSK_SYNC_BYTE : `DLSC_DSK_PATTERN;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) byte_strobe <= 1'b0;
      else        byte_strobe <= byte_en_q;
   end

   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         wire [7:0] pay_b = is_dsk_q ? dsk_b : fifo_data[gi*8 +: 8];
         wire [7:0] hs_d  = state_q[5] ? `DLSC_SYNC_BYTE :   // R7
                            state_q[6] ? pay_b :
                            state_q[7] ? trail_b : 8'h00;     // R6
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin   // R4
               lp_p[gi]           <= 1'b1;
               lp_n[gi]           <= 1'b1;
               lp_oe[gi]          <= 1'b1;
               hs_oe[gi]          <= 1'b0;
               hs_byte[gi*8 +: 8] <= 8'h00;
            end else begin   // R3 R20
               lp_p[gi]           <= st_lp11;
               lp_n[gi]           <= st_lp11 | state_q[2];
               lp_oe[gi]          <= ~st_hs;
               hs_oe[gi]          <= st_hs;
               hs_byte[gi*8 +: 8] <= hs_d;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// file: hw/dlsc_map.svh
// Register offsets, field positions, reset values and fixed codes of the lane controller
`ifndef DLSC_MAP_SVH
`define DLSC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define DLSC_OFF_TRAIL      4'h0
`define DLSC_OFF_INIT       4'h1
`define DLSC_OFF_LPX        4'h2
`define DLSC_OFF_ZERO       4'h3
`define DLSC_OFF_EXIT       4'h4
`define DLSC_OFF_CTRL       4'h5
`define DLSC_OFF_PERIOD     4'h6
`define DLSC_OFF_DSK_LEN    4'h7
`define DLSC_OFF_STATUS     4'h8

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define DLSC_CTRL_HIGH_RATE 0
`define DLSC_CTRL_INIT_DSK  1
`define DLSC_CTRL_PER_DSK   2

// ---------------------------------------------------------------
// Reset values (times in byte-clock counts, period in bursts, control bits)
// ---------------------------------------------------------------
`define DLSC_RST_TRAIL      6'h18
`define DLSC_RST_INIT       8'hff
`define DLSC_RST_LPX        8'h08
`define DLSC_RST_ZERO       8'h10
`define DLSC_RST_EXIT       8'h10
`define DLSC_RST_CTRL       8'h00
`define DLSC_RST_PERIOD     8'h40
`define DLSC_RST_DSK_LEN    8'h20

// ---------------------------------------------------------------
// Line codes and byte-clock divider
// ---------------------------------------------------------------
// Sync 00011101 in time order, bit 0 leaves first
`define DLSC_SYNC_BYTE      8'hb8
`define DLSC_DSK_SYNC_BYTE  8'hff
`define DLSC_DSK_PATTERN    8'h55
`define DLSC_BYTE_DIV       4'h4

`endif

// file: hw/dlsc_pkg.sv
// Shared types of the lane controller
package dlsc_pkg;

   typedef enum logic [8:0] {
      ST_INIT  = 9'b000000001,
      ST_STOP  = 9'b000000010,
      ST_LP01  = 9'b000000100,
      ST_LP00  = 9'b000001000,
      ST_ZERO  = 9'b000010000,
      ST_SYNC  = 9'b000100000,
      ST_DATA  = 9'b001000000,
      ST_TRAIL = 9'b010000000,
      ST_EXIT  = 9'b100000000
   } dlsc_state_t;

   typedef struct packed {
      logic       request;
      logic       wr_rdn;
      logic [3:0] offset;
      logic [7:0] wdata;
   } dlsc_cfg_req_t;

endpackage

// file: hw/dlsc_fifo.sv
// Payload FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module dlsc_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   // Drain side
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;

   wire push = in_valid & in_ready;
   wire pop  = out_ready & (cnt_q != '0);

   assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wp_q   <= '0;
         rp_q   <= '0;
         cnt_q  <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) begin
            mem_q[wp_q] <= in_data;
            wp_q        <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q  <= cnt_d;
         in_ready <= (cnt_d != (AW+1)'(DEPTH));
      end
   end

endmodule

`default_nettype wire

// file: tb/dlsc_rx_model.sv
// Passive receiver model watching lane 0 of the link
`timescale 1ns/100ps
`default_nettype none
module dlsc_rx_model (
   // Lane 0 as seen on the line
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       lp_p,
   input wire logic       lp_n,
   input wire logic       hs_oe,
   input wire logic [7:0] hs_byte,
   input wire logic       byte_strobe
);
   logic [7:0] cap [16];
   int         n_burst;
   int         n_dsk;
   int         n_zero;
   int         n_cap;
   int         run;
   int         gap;
   logic       lp00;
   logic       entry_ok;
   logic       synced;
   logic       hs_q;
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         n_burst = 0;
         n_dsk = 0;
         run = 0;
         hs_q = 0;
      end else begin
         if (!hs_oe) begin
            if (lp_p && lp_n)
               run++;
            else if (run > 0) begin
               gap = run;
               run = 0;
            end
            if (hs_q)
               n_burst++;
            if (!lp_p && !lp_n)
               lp00 = 1;
         end else begin
            if (!hs_q) begin
               entry_ok = lp00;
               synced = 0;
               n_cap = 0;
               n_zero = 0;
            end
            lp00 = 0;
            if (byte_strobe && synced) begin
               if (n_cap == 0 && hs_byte == 8'hff)
                  n_dsk++;
               if (n_cap < 16)
                  cap[n_cap] = hs_byte;
               n_cap++;
            end else if (byte_strobe) begin
               n_zero += int'(hs_byte == 8'h00);
               synced = (hs_byte == 8'hb8);
            end
         end
         hs_q = hs_oe;
      end
   end
endmodule
`default_nettype wire

// file: tb/dlsc_lane_ctrl_chk.sv
// Lane state checker bound to the lane controller
`timescale 1ns/100ps
`default_nettype none
module dlsc_lane_ctrl_chk #(
   parameter int LANES = 4
) (
   // Watched ports
   input wire logic               clk_sys,
   input wire logic               rst_n,
   input wire logic [LANES-1:0]   lp_p,
   input wire logic [LANES-1:0]   lp_n,
   input wire logic [LANES-1:0]   lp_oe,
   input wire logic [LANES-1:0]   hs_oe,
   input wire logic [LANES*8-1:0] hs_byte,
   input wire logic               byte_strobe,
   input wire logic               init_done
);
   localparam logic [LANES-1:0] ONES = '1;
   logic seen_q;
   always_ff @(posedge clk_sys)
      seen_q <= rst_n && hs_oe[0] && (seen_q || hs_byte[7:0] != 8'h00);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_mode_excl: assert property ((hs_oe & lp_oe) == '0)
      else $error("hs and lp drivers on together");
   a_lanes_same: assert property (hs_oe == '0 || hs_oe == ONES)
      else $error("lanes not in step");
   a_init_stop: assert property (!init_done |-> lp_p == ONES && lp_n == ONES && hs_oe == '0)
      else $error("lanes left stop state during init");
   a_lp01_entry: assert property ($fell(lp_p[0]) && lp_oe[0] |-> lp_n[0] && $past(lp_n[0]))
      else $error("entry did not start from lp11");
   a_hs_entry: assert property ($rose(hs_oe[0]) |-> $past(lp_p) == '0 && $past(lp_n) == '0)
      else $error("hs started without lp00");
   a_zero_first: assert property ($rose(hs_oe[0]) |-> hs_byte == '0)
      else $error("burst did not open with zeros");
   a_sync_first: assert property (hs_oe[0] && !seen_q && hs_byte[7:0] != 8'h00
      |-> hs_byte == {LANES{8'hb8}})
      else $error("first byte after zeros is not sync");
   a_exit_lp11: assert property ($fell(hs_oe[0]) |-> lp_oe == ONES && lp_p == ONES && lp_n == ONES)
      else $error("burst did not end in lp11");
   a_byte_hold: assert property (!$past(byte_strobe) |-> $stable(hs_byte) && $stable(hs_oe))
      else $error("lane output moved inside a byte time");
endmodule
bind dlsc_lane_ctrl dlsc_lane_ctrl_chk #(.LANES(LANES)) u_dlsc_lane_ctrl_chk (.*);
`default_nettype wire

// file: tb/tb_dlsc_lane_ctrl.sv
// Self-checking bench for the lane controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_dlsc_lane_ctrl;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        cfg_clk = 1'b0;
   logic        cfg_rst_n = 1'b0;
   logic        cfg_request = 1'b0;
   logic        cfg_wr_rdn = 1'b0;
   logic [3:0]  cfg_offset = 4'h0;
   logic [7:0]  cfg_wdata = 8'h00;
   logic        pl_valid = 1'b0;
   logic        pl_last = 1'b0;
   logic [31:0] pl_data = 32'h0;
   logic        cfg_ready, cfg_rdata_valid, pl_ready, byte_strobe, init_done;
   logic [7:0]  cfg_rdata, rd;
   logic [3:0]  lp_p, lp_n, lp_oe, hs_oe;
   logic [31:0] hs_byte;
   logic [7:0]  exp_rst [10] = '{8'h18, 8'h0f, 8'h08, 8'h10, 8'h10, 8'h00, 8'h40, 8'h20,
                                 8'h01, 8'h00};
   int          n_fail = 0, n_compared = 0, n_init = 0, i, t;
   dlsc_lane_ctrl #(
      .BYTE_DIV (4'h2),
      .DEF_INIT (8'h0f)
   ) u_dlsc_lane_ctrl (.*);
   dlsc_rx_model u_dlsc_rx_model (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .lp_p        (lp_p[0]),
      .lp_n        (lp_n[0]),
      .hs_oe       (hs_oe[0]),
      .hs_byte     (hs_byte[7:0]),
      .byte_strobe (byte_strobe)
   );
   always #12.5 clk_sys = ~clk_sys;
   initial begin
      #37;
      forever #100 cfg_clk = ~cfg_clk;
   end
   always @(posedge clk_sys)
      if (rst_n && init_done !== 1'b1)
         n_init <= n_init + 1;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic bound(input int k, input int lim);
      if (k >= lim) begin
         n_fail++;
         $display("ERROR wait expected done seen timeout");
         give_verdict();
      end
   endtask
   task automatic cfg(input logic wr, input logic [3:0] off, input logic [7:0] wd);
      int k;
      for (k = 0; k < 50 && cfg_ready !== 1'b1; k++)
         @(posedge clk_sys);
      bound(k, 50);
      @(posedge cfg_clk);
      @(posedge clk_sys);
      cfg_request <= 1'b1;
      cfg_wr_rdn <= wr;
      cfg_offset <= off;
      cfg_wdata <= wd;
      @(negedge cfg_clk);
      repeat (wr ? 6 : 4) @(posedge clk_sys);
      for (k = 0; k < 8 && !wr && cfg_rdata_valid !== 1'b1; k++)
         @(posedge clk_sys);
      bound(k, 8);
      @(posedge clk_sys);
      rd = cfg_rdata;
      cfg_request <= 1'b0;
   endtask
   task automatic push(input logic [7:0] b, input logic last);
      pl_valid <= 1'b1;
      pl_data <= {b ^ 8'h03, b ^ 8'h02, b ^ 8'h01, b};
      pl_last <= last;
      @(posedge clk_sys);
      for (t = 0; t < 500 && pl_ready !== 1'b1; t++)
         @(posedge clk_sys);
      bound(t, 500);
   endtask
   task automatic wait_bursts(input int n);
      for (t = 0; t < 4000 && !(u_dlsc_rx_model.n_burst == n && hs_oe[0] === 1'b0); t++)
         @(posedge clk_sys);
      bound(t, 4000);
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      cfg_rst_n <= 1'b1;
      for (i = 0; i < 8; i++)
         push(8'h10 + 8'(i), i == 7);
      pl_valid <= 1'b0;
      #1 `CHK("pl_ready full", 1'b0, pl_ready)
      wait_bursts(1);
      `CHK("init cycles", 1'b1, n_init >= 30)
      `CHK("entry seq", 1'b1, u_dlsc_rx_model.entry_ok)
      `CHK("zero bytes", 17, u_dlsc_rx_model.n_zero)
      for (i = 0; i < 8; i++)
         `CHK("payload", 8'h10 + 8'(i), u_dlsc_rx_model.cap[i])
      for (i = 0; i < 10; i++) begin
         cfg(1'b0, 4'(i), 8'h00);
         `CHK("reset value", exp_rst[i], rd)
      end
      cfg(1'b1, 4'h0, 8'hff);
      cfg(1'b1, 4'h9, 8'h77);
      cfg(1'b1, 4'h2, 8'h03);
      cfg(1'b0, 4'h0, 8'h00);
      `CHK("trail width", 8'h3f, rd)
      cfg(1'b0, 4'h9, 8'h00);
      `CHK("unmapped", 8'h00, rd)
      cfg(1'b0, 4'h2, 8'h00);
      `CHK("lpx written", 8'h03, rd)
      cfg_rst_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      cfg_rst_n <= 1'b1;
      cfg(1'b0, 4'h2, 8'h00);
      `CHK("lpx after cfg reset", 8'h08, rd)
      cfg(1'b1, 4'h3, 8'h02);
      cfg(1'b1, 4'h4, 8'h05);
      cfg(1'b1, 4'h5, 8'h01);
      push(8'h5a, 1'b1);
      pl_valid <= 1'b0;
      wait_bursts(3);
      `CHK("deskew bursts", 1, u_dlsc_rx_model.n_dsk)
      `CHK("zero bytes", 3, u_dlsc_rx_model.n_zero)
      `CHK("payload", 8'h5a, u_dlsc_rx_model.cap[0])
      `CHK("exit hold", 1'b1, u_dlsc_rx_model.gap >= 12)
      cfg(1'b1, 4'h6, 8'h01);
      cfg(1'b1, 4'h5, 8'h05);
      push(8'h33, 1'b1);
      pl_valid <= 1'b0;
      wait_bursts(5);
      `CHK("periodic deskew", 2, u_dlsc_rx_model.n_dsk)
      give_verdict();
   end
endmodule
`default_nettype wire
